// ### src/clock_fanout_pkg.sv
// ---------------------------------------------------------------
// Shared constants for the gated clock fanout
// ---------------------------------------------------------------
package clock_fanout_pkg;

  // Pin input conditioning
  localparam int unsigned SYNC_STAGES      = 3;
  localparam logic        OPEN_PIN_LEVEL   = 1'b1;

  // Fanout shape
  localparam int unsigned FANOUT_COUNT     = 4;

  // Pin index in the conditioned input vector
  localparam int unsigned PIN_INPUT_A      = 0;
  localparam int unsigned PIN_INPUT_B      = 1;
  localparam int unsigned PIN_SELECT       = 2;
  localparam int unsigned PIN_GATE         = 3;
  localparam int unsigned PIN_COUNT        = 4;

  // Reset values of the gating state
  localparam logic        GATE_RESET       = 1'b1;
  localparam logic        SELECTED_RESET   = 1'b1;

endpackage : clock_fanout_pkg

// ### src/pin_conditioner.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ---------------------------------------------------------------
module pin_conditioner
  import clock_fanout_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
    logic level;
  } cond_state_t;

  cond_state_t state;
  cond_state_t next_state;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Stage one feeds only stage two; filter looks at two and three
  always_comb
  begin
    next_state        = state;
    next_state.stage1 = i_pin;
    next_state.stage2 = state.stage1;
    next_state.stage3 = state.stage2;
    if (state.stage2 == state.stage3)
    begin
      next_state.level = state.stage3;
    end
  end

  // Open pins idle high, so reset to high as well
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= '{OPEN_PIN_LEVEL, OPEN_PIN_LEVEL, OPEN_PIN_LEVEL, OPEN_PIN_LEVEL};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_level = state.level;

endmodule : pin_conditioner

// ### src/clock_mux_gated_fanout.sv
`timescale 1ns/1ps
// Function
// [RQ1] Select high picks input a, else b
// [RQ2] Disable forces outputs at next falling edge
// [RQ3] Gate latched only on selected falling edges
// [RQ4] Enabled: four true copies, four inverted
// [RQ5] Open gate pin reads as enabled
// [RQ6] Open select or data pin reads high
// [RQ7] Disabled complement outputs held high
module clock_mux_gated_fanout
  import clock_fanout_pkg::*;
#(
  parameter int unsigned WIDTH = FANOUT_COUNT
)
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_clock_input_a,
  input  wire logic             i_clock_input_b,
  input  wire logic             i_select,
  input  wire logic             i_gate,
  input  wire logic [PIN_COUNT-1:0] i_pin_open,
  output logic [WIDTH-1:0]      o_true_outputs,
  output logic [WIDTH-1:0]      o_complement_outputs
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The fanout must have at least one output pair to drive
  if (WIDTH < 1)
  begin : g_width_check
    $error("clock_mux_gated_fanout: WIDTH must be at least one");
  end

  // The pin vector must hold all four conditioned pins
  if (PIN_COUNT < 4)
  begin : g_pin_count_check
    $error("clock_mux_gated_fanout: PIN_COUNT must be at least four");
  end

  // Every pin index must land inside the pin vector
  if ((PIN_INPUT_A >= PIN_COUNT) || (PIN_INPUT_B >= PIN_COUNT) ||
      (PIN_SELECT >= PIN_COUNT) || (PIN_GATE >= PIN_COUNT))
  begin : g_pin_range_check
    $error("clock_mux_gated_fanout: pin index outside the pin vector");
  end

  // Each conditioned pin needs a slot of its own
  if ((PIN_INPUT_A == PIN_INPUT_B) || (PIN_INPUT_A == PIN_SELECT) ||
      (PIN_INPUT_A == PIN_GATE) || (PIN_INPUT_B == PIN_SELECT) ||
      (PIN_INPUT_B == PIN_GATE) || (PIN_SELECT == PIN_GATE))
  begin : g_pin_index_check
    $error("clock_mux_gated_fanout: pin indices must be distinct");
  end

  // The conditioner is built for exactly three stages
  if (SYNC_STAGES != 3)
  begin : g_sync_check
    $error("clock_mux_gated_fanout: SYNC_STAGES must be three");
  end

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // An unconnected pin sits at its pull-up level, otherwise the
  // driven level counts; applied to every pin, hence a function
  function automatic logic resolve_pin
  (
    input logic is_open,
    input logic driven
  );
    logic level;
    level = is_open ? OPEN_PIN_LEVEL : driven;
    return level;
  endfunction : resolve_pin

  // Two-way selection between the conditioned data inputs
  function automatic logic pick_input
  (
    input logic sel,
    input logic in_a,
    input logic in_b
  );
    logic picked;
    picked = sel ? in_a : in_b;
    return picked;
  endfunction : pick_input

  typedef struct packed {
    logic             gate_latch;
    logic             prev_selected;
    logic [WIDTH-1:0] true_outputs;
    logic [WIDTH-1:0] complement_outputs;
  } fanout_state_t;

  fanout_state_t        state;
  fanout_state_t        next_state;
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_level;
  logic                 selected;

  // ---------------------------------------------------------------
  // Pin resolution and conditioning
  // ---------------------------------------------------------------
  // An open pin is pulled up before it reaches the synchroniser
  always_comb
  begin
    pin_raw              = '0;
    pin_raw[PIN_INPUT_A] = resolve_pin(i_pin_open[PIN_INPUT_A], i_clock_input_a); // [RQ6]
    pin_raw[PIN_INPUT_B] = resolve_pin(i_pin_open[PIN_INPUT_B], i_clock_input_b); // [RQ6]
    pin_raw[PIN_SELECT]  = resolve_pin(i_pin_open[PIN_SELECT], i_select);         // [RQ6]
    pin_raw[PIN_GATE]    = resolve_pin(i_pin_open[PIN_GATE], i_gate);             // [RQ5]
  end

  // Resolving before the synchroniser keeps an open pin from ever
  // showing a stray level inside the clock domain

  // Every pin comes from outside the clock domain
  for (genvar p = 0; p < PIN_COUNT; p++)
  begin : g_pins
    pin_conditioner u_cond
    (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_pin     (pin_raw[p]),
      .o_level   (pin_level[p])
    );
  end

  // ---------------------------------------------------------------
  // Mux, enable latch and fanout
  // ---------------------------------------------------------------
  // Two-way input selection; every pin has the same delay, so the
  // mux after the synchronisers matches a mux in front of them
  assign selected = pick_input(pin_level[PIN_SELECT],
                               pin_level[PIN_INPUT_A],
                               pin_level[PIN_INPUT_B]); // [RQ1]

  logic selected_fell;
  logic latch_value;

  // A falling edge of the selected signal is the only moment at
  // which the enable may change; a select change counts only when the selected level drops
  assign selected_fell = state.prev_selected & ~selected; // [RQ3]

  // The gate level is latched and used in the same update, so the
  // outputs stop at the very falling edge and no runt pulse escapes
  assign latch_value = selected_fell ? pin_level[PIN_GATE]
                                     : state.gate_latch; // [RQ3]

  // Latching only on falling edges avoids truncated output pulses
  always_comb
  begin
    next_state               = state;
    next_state.prev_selected = selected;
    next_state.gate_latch    = latch_value; // [RQ3]
    if (latch_value)
    begin
      next_state.true_outputs = {WIDTH{selected}}; // [RQ4]
    end
    else
    begin
      next_state.true_outputs = '0; // [RQ2]
    end
    next_state.complement_outputs = ~next_state.true_outputs; // [RQ4] [RQ7]
  end

  // Reset state matches all pins open: enabled, input high
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= '{GATE_RESET, SELECTED_RESET, {WIDTH{1'b1}}, {WIDTH{1'b0}}};
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Both output sets come straight from the state register; the
  // cost is one clock of latency on top of the three-stage input
  // conditioning and its filter register, five clocks from a settled pin to the outputs.
  // Pulses shorter than two clocks on a pin may be filtered away,
  // so the fanout only follows inputs well below the clock rate.
  assign o_true_outputs       = state.true_outputs;       // [RQ4]
  assign o_complement_outputs = state.complement_outputs; // [RQ7]

endmodule : clock_mux_gated_fanout

// ### verif/fanout_assertions.sv
`timescale 1ns/1ps
// ----
// Fanout checks
// ----
module fanout_assertions
  import clock_fanout_pkg::*;
#(parameter int unsigned WIDTH = FANOUT_COUNT)
(
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst,
  input wire logic                 i_clock_input_a,
  input wire logic                 i_clock_input_b,
  input wire logic                 i_select,
  input wire logic                 i_gate,
  input wire logic [PIN_COUNT-1:0] i_pin_open,
  input wire logic [WIDTH-1:0]     o_true_outputs,
  input wire logic [WIDTH-1:0]     o_complement_outputs
);
  // Open pins read high; muxing before the delay equals muxing after
  wire logic s = i_select | i_pin_open[PIN_SELECT];
  wire logic g = i_gate | i_pin_open[PIN_GATE];
  wire logic v = s ? (i_clock_input_a | i_pin_open[PIN_INPUT_A])
                   : (i_clock_input_b | i_pin_open[PIN_INPUT_B]);
  logic [3:0] sp, gp;
  logic       prev, lat, e;
  wire logic  fall = prev & ~sp[3];
  wire logic  nl   = fall ? gp[3] : lat;
  // Reference pipeline, latch and output
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      {sp, gp, prev, lat, e} <= '1;
    else
      {sp, gp, prev, lat, e} <= {sp[2:0], v, gp[2:0], g, sp[3], nl, nl & sp[3]};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_out_model: assert property (o_true_outputs == {WIDTH{e}})
    else $error("true outputs differ from model");
  chk_comp_inverse: assert property (o_complement_outputs == ~o_true_outputs)
    else $error("complement not inverse");
  chk_copies_same: assert property (o_true_outputs == {WIDTH{o_true_outputs[0]}})
    else $error("copies differ");
  chk_rise_cause: assert property ($rose(o_true_outputs[0]) |-> $past(v, 5) && lat)
    else $error("rise without cause");
  chk_fall_cause: assert property ($fell(o_true_outputs[0]) |-> !$past(v, 5))
    else $error("fall without cause");
  chk_gate_off: assert property (fall && !gp[3] |=> o_true_outputs == '0)
    else $error("disable missed");
  chk_reset_state: assert property (disable iff (1'b0) i_rst |-> o_true_outputs == '1)
    else $error("bad reset state");
endmodule : fanout_assertions

bind clock_mux_gated_fanout fanout_assertions #(.WIDTH(WIDTH)) fanout_assertions_i (.*);

// ### verif/pin_source.sv
`timescale 1ns/1ps
// ----
// Pin source model
// ----
module pin_source
(
  input  wire logic [3:0] i_want,
  input  wire logic       i_ref_clk,
  input  wire logic [3:0] i_open,
  output logic      [3:0] o_pins
);
  logic [3:0] last = 4'h0;
  // Floating pin toggles, so a design that ignores open flags sees noise
  always_ff @(posedge i_ref_clk)
    last <= o_pins;
  assign o_pins = (i_want & ~i_open) | (~last & i_open);
endmodule : pin_source

// ### verif/test_clock_mux_gated_fanout.sv
`timescale 1ns/1ps
// ----
// Bench, pins {gate, select, b, a}
// ----
module test_clock_mux_gated_fanout;
  logic       i_ref_clk = 0;
  logic       i_rst = 0;
  logic [3:0] want = '1, opn = '0, pins, t, c;
  int         n_fail = 0, n_tests = 0;
  `define CMP(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t out %b", $time, a); end end
  pin_source pin_source_i (.i_want(want), .i_ref_clk(i_ref_clk), .i_open(opn), .o_pins(pins));
  clock_mux_gated_fanout clock_mux_gated_fanout_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_clock_input_a(pins[0]), .i_clock_input_b(pins[1]), .i_select(pins[2]), .i_gate(pins[3]),
    .i_pin_open(opn), .o_true_outputs(t), .o_complement_outputs(c));
  // Clock, 25 ns period
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  task put(input logic [3:0] w, input logic [3:0] o, input int n);
    @(posedge i_ref_clk);
    #1 want = w;
    opn = o;
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : put
  task exp(input logic x);
    `CMP(t, {4{x}})
    `CMP(c, ~{4{x}})
  endtask : exp
  task s_mux;
    put(4'b1110, 0, 6); exp(0);
    put(4'b1101, 0, 6); exp(1);
    put(4'b1001, 0, 6); exp(0);
    put(4'b1010, 0, 6); exp(1);
  endtask : s_mux
  task s_gate;
    put(4'b1101, 0, 6); exp(1);
    put(4'b0101, 0, 8); exp(1);
    put(4'b0100, 0, 6); exp(0);
    put(4'b0101, 0, 6); exp(0);
    put(4'b1101, 0, 6); exp(0);
    put(4'b1100, 0, 6); exp(0);
    put(4'b1101, 0, 6); exp(1);
  endtask : s_gate
  task s_open;
    put(4'b0010, 4'b1101, 8); exp(1);
    put(4'b0000, 4'b1100, 6); exp(0);
    put(4'b0001, 4'b1100, 6); exp(1);
  endtask : s_open
  task s_reset;
    put(4'b1100, 0, 6); exp(0);
    i_rst = 1;
    #2 exp(1);
    put(4'b1100, 0, 1);
    i_rst = 0;
    put(4'b1100, 0, 6); exp(0);
  endtask : s_reset
  task close_out;
    $display("fails %0d tests %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Main sequence; reset rises after time zero so its edge is seen
  initial
  begin
    #1 i_rst = 1;
    repeat (6) @(posedge i_ref_clk);
    #1 i_rst = 0;
    s_mux;
    s_gate;
    s_open;
    s_reset;
    close_out;
  end
  // Watchdog, far beyond the few microseconds needed
  initial
  begin
    #20us n_fail++;
    close_out;
  end
endmodule : test_clock_mux_gated_fanout
